/* cpu_store_sub_trap_ops_tb.sv */
// Self-checking bench for the execution slice and its memory model.
// Assumes the core answers each bus request with a one-cycle ack.
`timescale 1ns/1ps
`default_nettype none
module cpu_store_sub_trap_ops_tb;
  import csto_pkg::*;
  logic         clk = 0, rst = 1, irq_n = 1, wake = 0, ack;
  logic         rpin_n = 1, allow, por, wsvc;
  int           n_por = 0, n_wake = 0;
  csto_wb_req_t wb = '0;
  logic [31:0]  rd;
  logic [7:0]   rdat;
  csto_mem_t    mp;
  csto_stop_t   st;
  int           num_errors = 0, samples_checked = 0;
  // 20 MHz clock
  always #25 clk = ~clk;
  csto_core DUT (.I_CLK(clk), .I_RST(rst), .I_CE(1'b1), .I_WB(wb),
    .O_WB_DAT(rd), .O_WB_ACK(ack), .O_MEM(mp), .I_MEM_RDATA(rdat),
    .I_RESET_PIN_N(rpin_n), .I_IRQ_PIN_N(irq_n), .I_WAKE_INT(wake),
    .O_INT_ALLOW(allow), .O_STOP(st), .O_POR_REQ(por), .O_WAKE_SVC(wsvc));
  // Count exit pulses; each stands for one cycle only
  always @(posedge clk) begin
    if (por === 1'b1) n_por++;
    if (wsvc === 1'b1) n_wake++;
  end
  csto_mem_model MEM (.I_CLK(clk), .I_MEM(mp), .O_RDATA(rdat));
  task automatic results;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until ack is sampled high at a rising edge
  task automatic bus(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    wb <= '{1'b1, 1'b1, we, a, 4'hF, d};
    do @(posedge clk); while (ack !== 1'b1);
    q = rd;
    wb <= '0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rg(input logic [7:0] a, input logic [31:0] m, e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q & m, e);
  endtask
  // Start a command and wait for busy to fall, bounded
  task automatic run(input logic [8:0] op);
    logic [31:0] q;
    wr(REG_CMD, {23'h0, op});
    repeat (20) begin
      bus(1'b0, REG_STATUS, 32'h0, q);
      if (q[ST_BUSY] === 1'b0) return;
    end
    check(q, 32'h0);
  endtask
  task automatic stop(input logic [31:0] cfg);
    wr(REG_CFG, cfg);
    wr(REG_CMD, {24'h0, OP_STOP});
    repeat (4) @(posedge clk);
  endtask
  // Subtract with H preset and I clear; expectation from operand signs
  task automatic sub(input logic [7:0] a, m, input logic fm);
    logic [7:0] r;
    r = a - m;
    MEM.mem[16'h0040] = m;
    wr(REG_ACC, {24'h0, a});
    wr(REG_FLAGS, 32'h70);
    wr(REG_OPND, fm ? 32'h40 : {24'h0, m});
    run({1'b0, fm ? HI_DIR : HI_IMM, LO_SUB});
    rg(REG_ACC, 32'hFF, {24'h0, r});
    rg(REG_FLAGS, 32'hFF, {24'h0, a[7] & ~m[7] & ~r[7] | ~a[7] & m[7] & r[7],
       4'hE, r[7], r == 8'h0, m > a});
  endtask
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #1ms;
    num_errors++;
    results;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rg(8'h1C, 32'hFFFFFFFF, 32'h0);
    wr(REG_FLAGS, 32'h0);
    run({1'b0, OP_SEI});
    rg(REG_FLAGS, 32'hFF, 32'h68);
    rg(REG_STATUS, 32'h10, 32'h0);
    check(allow, 1'b0);
    wr(REG_ACC, 32'h97);
    run({1'b0, OP_TAP});
    rg(REG_FLAGS, 32'hFF, 32'hF7);
    rg(REG_STATUS, 32'h10, 32'h10);
    sub(8'h80, 8'h01, 1'b0);
    sub(8'h01, 8'h02, 1'b1);
    sub(8'h7F, 8'hFF, 1'b1);
    sub(8'h05, 8'h05, 1'b1);
    wr(REG_ACC, 32'h801200);
    wr(REG_FLAGS, 32'h81);
    wr(REG_OPND, 32'h40);
    run({1'b0, HI_DIR, LO_STA});
    check(MEM.mem[16'h40], 8'h00);
    rg(REG_FLAGS, 32'hFF, 32'h63);
    wr(REG_OPND, 32'h41);
    run({1'b0, HI_DIR, LO_STX});
    check(MEM.mem[16'h41], 8'h12);
    rg(REG_FLAGS, 32'hFF, 32'h61);
    wr(REG_OPND, 32'h50);
    run({1'b0, OP_STORE_INDEX_PAIR_DIR});
    check({MEM.mem[16'h50], MEM.mem[16'h51]}, 16'h8012);
    rg(REG_FLAGS, 32'hFF, 32'h65);
    rg(REG_ACC, 32'hFFFFFF, 32'h801200);
    MEM.mem[16'hFFFC] = 8'hAB;
    MEM.mem[16'hFFFD] = 8'hCD;
    wr(REG_SPPC, 32'h123400FF);
    wr(REG_ACC, 32'h3C97);
    run({1'b0, OP_SWI});
    check({MEM.mem[255], MEM.mem[254], MEM.mem[253]}, 24'h35123C);
    check({MEM.mem[252], MEM.mem[251]}, 16'h9765);
    rg(REG_SPPC, 32'hFFFFFFFF, 32'hABCD00FA);
    rg(REG_FLAGS, 32'hFF, 32'h6D);
    stop(32'h3);
    check({st.irq_pin_en, st.osc_en, st.level}, 4'hB);
    rg(REG_FLAGS, 32'h08, 32'h0);
    wake <= 1'b1;
    repeat (4) @(posedge clk);
    wake <= 1'b0;
    check({st.osc_en, st.self_clk, st.level}, 4'hC);
    check(n_wake, 1);
    stop(32'h5);
    check({st.osc_en, st.level}, 3'h7);
    irq_n <= 1'b0;
    repeat (4) @(posedge clk);
    irq_n <= 1'b1;
    MEM.mem[16'hFFFE] = 8'h12;
    MEM.mem[16'hFFFF] = 8'h34;
    stop(32'h1);
    check(st.level, LVL_DEEP);
    irq_n <= 1'b0;
    repeat (8) @(posedge clk);
    irq_n <= 1'b1;
    repeat (2) @(posedge clk);
    rg(REG_SPPC, 32'hFFFFFFFF, 32'h123400FF);
    rg(REG_FLAGS, 32'hFF, 32'h68);
    wr(REG_SPPC, 32'h00000010);
    stop(32'h2);
    check(st.level, LVL_MID);
    rpin_n <= 1'b0;
    repeat (8) @(posedge clk);
    rpin_n <= 1'b1;
    repeat (2) @(posedge clk);
    rg(REG_SPPC, 32'hFFFFFFFF, 32'h123400FF);
    check(n_por, 2);
    check(n_wake, 2);
    results;
  end
endmodule
`default_nettype wire

/* csto_core.sv */
// Execution slice: interrupt mask set, stores, subtract, stop entry,
// software trap and accumulator-to-flags transfer, with register access.
// Assumes memory returns read data combinationally for O_MEM.addr and
// that pin inputs are asynchronous to I_CLK.
//
// Chosen here: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - Mask-set opcode sets I in one cycle, other flags kept.
// - I changes only at the end of the mask-set cycle.
// - A set mask blocks maskable requests before the next instruction.
// - Accumulator store writes A; N, Z from A, V cleared.
// - Index pair store writes H at M, X at M+1; 16-bit N, Z.
// - Index low store writes X; N, Z from X, V cleared.
// - Subtract puts A minus operand in A; V N Z C updated.
// - Carry set exactly when unsigned operand exceeds accumulator.
// - Overflow on sign mismatch as for two's complement subtract.
// - Stop enables the interrupt pin, clears I, then halts oscillator.
// - Stop enters the configured deep, middle or light level.
// - Deep levels exit via reset or interrupt pin to reset vector.
// - Only the light level exits by interrupt into its service.
// - Debug enable forces light level with oscillator running.
// - Stop recovery selects the self-clocked system clock.
// - Trap increments PC, pushes PCL PCH X A flags, SP down each.
// - Stacked flags: V bit 7, ones in 6 and 5, H I N Z C below.
// - Trap then sets I and loads PC from its vector, unmaskable.
// - Transfer copies A into flags in one cycle, A kept.
// - Transfer clearing I holds off interrupts one bus cycle.
module csto_core (
  // Clock, reset, enable
  input  wire logic                  I_CLK,
  input  wire logic                  I_RST,
  input  wire logic                  I_CE,
  // Wishbone slave
  input  wire csto_pkg::csto_wb_req_t I_WB,
  output logic [csto_pkg::WB_DW-1:0] O_WB_DAT,
  output logic                       O_WB_ACK,
  // Memory port
  output csto_pkg::csto_mem_t        O_MEM,
  input  wire logic [7:0]            I_MEM_RDATA,
  // Pins and wake requests
  input  wire logic                  I_RESET_PIN_N,
  input  wire logic                  I_IRQ_PIN_N,
  input  wire logic                  I_WAKE_INT,
  // Interrupt gating and stop control
  output logic                       O_INT_ALLOW,
  output csto_pkg::csto_stop_t       O_STOP,
  output logic                       O_POR_REQ,
  output logic                       O_WAKE_SVC
);
  import csto_pkg::*;

  csto_state_t st_r;
  csto_mem_t   mem_r;
  csto_stop_t  stop_r;
  logic [7:0]  a_r, x_r, h_r, ccr_r;
  logic [15:0] sp_r, pc_r, opnd_r, vec_r;
  logic [8:0]  cmd_r;
  logic [2:0]  cfg_r;
  logic [2:0]  cnt_r;
  logic        ack_r, tap_dly_r, por_r, wake_r;
  logic [31:0] rdat_r;
  logic        rst_m_r, rst_s_r, irq_m_r, irq_s_r;

  // Flag update with named bits; C only when asked
  function automatic logic [7:0] upd_flags(input logic [7:0] c,
      input logic n, input logic z, input logic v,
      input logic cy, input logic use_c);
    logic [7:0] r;
    r        = c | CCR_ONES;
    r[CCR_N] = n;
    r[CCR_Z] = z;
    r[CCR_V] = v;
    if (use_c) r[CCR_C] = cy;
    return r;
  endfunction

  // Opcode group test: store/subtract families across addressing forms
  function automatic logic in_grp(input logic pre, input logic [7:0] op,
      input logic [3:0] lo, input logic [3:0] first_hi);
    logic r;
    r = 1'b0;
    if (op[3:0] == lo) begin
      if (pre) r = (op[7:4] == HI_SP2) || (op[7:4] == HI_SP1);
      else     r = (op[7:4] >= first_hi) && (op[7:4] <= HI_IX);
    end
    return r;
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] wb_merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction

  // Instruction decode
  wire       pre      = cmd_r[CMD_PRE_BIT];
  wire [7:0] opc      = cmd_r[7:0];
  wire       is_store_index_pair  = (!pre && (opc == OP_STORE_INDEX_PAIR_DIR || opc == OP_STORE_INDEX_PAIR_EXT))
                        || (pre && opc == OP_STORE_INDEX_PAIR_SP1);
  wire       is_inh   = !pre;
  csto_op_t  op;
  assign op = (is_inh && opc == OP_SEI)    ? OPC_SEI  :
              (is_inh && opc == OP_STOP)   ? OPC_STOP :
              (is_inh && opc == OP_SWI)    ? OPC_SWI  :
              (is_inh && opc == OP_TAP)    ? OPC_TAP  :
              is_store_index_pair                      ? OPC_STORE_INDEX_PAIR :
              in_grp(pre, opc, LO_STA, HI_DIR) ? OPC_STA :
              in_grp(pre, opc, LO_STX, HI_DIR) ? OPC_STX :
              in_grp(pre, opc, LO_SUB, HI_IMM) ? OPC_SUB : OPC_NONE;
  wire sub_imm = !pre && (opc[7:4] == HI_IMM);

  // Subtract datapath; immediate operand from the operand register
  wire [7:0] sub_m = (st_r == S_SUB_RD) ? I_MEM_RDATA : opnd_r[7:0];
  wire [8:0] sub_d = {1'b0, a_r} - {1'b0, sub_m};
  wire [7:0] sub_r = sub_d[7:0];
  wire       sub_c = sub_d[8];
  wire       sub_v = (a_r[7] & ~sub_m[7] & ~sub_r[7])
                   | (~a_r[7] & sub_m[7] & sub_r[7]);
  wire [7:0] sub_ccr = upd_flags(ccr_r, sub_r[7], sub_r == 8'h00,
                                 sub_v, sub_c, 1'b1);

  // Store flag results
  wire [7:0] sta_ccr  = upd_flags(ccr_r, a_r[7], a_r == 8'h00,
                                  1'b0, 1'b0, 1'b0);
  wire [7:0] stx_ccr  = upd_flags(ccr_r, x_r[7], x_r == 8'h00,
                                  1'b0, 1'b0, 1'b0);
  wire [7:0] store_index_pair_ccr = upd_flags(ccr_r, h_r[7], {h_r, x_r} == 16'h0000,
                                  1'b0, 1'b0, 1'b0);

  // Stack byte by push step: PCL, PCH, X, A, flags
  wire [7:0] push_byte = (cnt_r == 3'h0) ? pc_r[7:0]  :
                         (cnt_r == 3'h1) ? pc_r[15:8] :
                         (cnt_r == 3'h2) ? x_r        :
                         (cnt_r == 3'h3) ? a_r        :
                         (ccr_r | CCR_ONES);

  // Stop level choice; debug keeps the light level
  wire       dbg_en   = cfg_r[CFG_DBG_BIT];
  wire [1:0] cfg_lvl  = (cfg_r[1:0] == LVL_RUN) ? LVL_LIGHT : cfg_r[1:0];
  wire [1:0] stop_lvl = dbg_en ? LVL_LIGHT : cfg_lvl;
  wire       deep     = (stop_r.level == LVL_DEEP)
                        || (stop_r.level == LVL_MID);
  wire       irq_low  = stop_r.irq_pin_en && !irq_s_r;
  wire       deep_exit  = deep && (!rst_s_r || irq_low);
  wire       light_exit = !deep && (I_WAKE_INT || irq_low);

  // Register bus decode
  wire bus_req = I_WB.cyc && I_WB.stb && !ack_r;
  wire wb_wr   = bus_req && I_WB.we && (st_r == S_IDLE);
  // Merged write words; a function result cannot be part-selected
  wire [31:0] opnd_wr = wb_merge({16'h0000, opnd_r}, I_WB.dat, I_WB.sel);
  wire [31:0] sppc_wr = wb_merge({pc_r, sp_r}, I_WB.dat, I_WB.sel);
  wire [31:0] rd_word =
    (I_WB.adr == REG_CMD)    ? {23'h000000, cmd_r}            :
    (I_WB.adr == REG_OPND)   ? {16'h0000, opnd_r}             :
    (I_WB.adr == REG_ACC)    ? {8'h00, h_r, x_r, a_r}         :
    (I_WB.adr == REG_SPPC)   ? {pc_r, sp_r}                   :
    (I_WB.adr == REG_FLAGS)  ? {24'h000000, ccr_r}            :
    (I_WB.adr == REG_CFG)    ? {29'h00000000, cfg_r}          :
    (I_WB.adr == REG_STATUS) ? {27'h0000000, O_INT_ALLOW,
                                stop_r.level,
                                st_r == S_STOPPED,
                                st_r != S_IDLE}              : 32'h00000000;

  // Mask gating: a new I blocks from the next cycle on
  assign O_INT_ALLOW = !ccr_r[CCR_I] && !tap_dly_r;
  assign O_WB_ACK    = ack_r;
  assign O_WB_DAT    = rdat_r;
  assign O_MEM       = mem_r;
  assign O_STOP      = stop_r;
  assign O_POR_REQ   = por_r;
  assign O_WAKE_SVC  = wake_r;

  // Pin synchronisers; first stage read only by the second
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rst_m_r <= 1'b1;
      rst_s_r <= 1'b1;
      irq_m_r <= 1'b1;
      irq_s_r <= 1'b1;
    end else if (I_CE) begin
      rst_m_r <= I_RESET_PIN_N;
      rst_s_r <= rst_m_r;
      irq_m_r <= I_IRQ_PIN_N;
      irq_s_r <= irq_m_r;
    end
  end

  // Bus answer: ack one cycle after the request, then dropped
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      ack_r  <= 1'b0;
      rdat_r <= 32'h00000000;
    end else if (I_CE) begin
      ack_r  <= bus_req;
      if (bus_req) rdat_r <= rd_word;
    end
  end

  // Sequencer and architectural state
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_r      <= S_IDLE;
      mem_r     <= '0;
      stop_r    <= '0;
      a_r       <= 8'h00;
      x_r       <= 8'h00;
      h_r       <= 8'h00;
      ccr_r     <= CCR_RESET;
      sp_r      <= SP_RESET;
      pc_r      <= 16'h0000;
      opnd_r    <= 16'h0000;
      vec_r     <= VEC_RST;
      cmd_r     <= 9'h000;
      cfg_r     <= {1'b0, LVL_LIGHT};
      cnt_r     <= 3'h0;
      tap_dly_r <= 1'b0;
      por_r     <= 1'b0;
      wake_r    <= 1'b0;
    end else if (I_CE) begin
      mem_r.we  <= 1'b0;
      mem_r.re  <= 1'b0;
      tap_dly_r <= 1'b0;
      por_r     <= 1'b0;
      wake_r    <= 1'b0;
      case (st_r)
        S_IDLE: begin
          // Register writes only while idle; busy writes are dropped
          if (wb_wr) begin
            case (I_WB.adr)
              REG_OPND:  opnd_r <= opnd_wr[15:0];
              REG_ACC: begin
                a_r <= I_WB.sel[0] ? I_WB.dat[7:0]   : a_r;
                x_r <= I_WB.sel[1] ? I_WB.dat[15:8]  : x_r;
                h_r <= I_WB.sel[2] ? I_WB.dat[23:16] : h_r;
              end
              REG_SPPC: begin
                sp_r <= sppc_wr[15:0];
                pc_r <= sppc_wr[31:16];
              end
              REG_FLAGS: if (I_WB.sel[0]) ccr_r <= I_WB.dat[7:0] | CCR_ONES;
              REG_CFG:   if (I_WB.sel[0]) cfg_r <= I_WB.dat[2:0];
              REG_CMD: begin
                if (I_WB.sel[0]) begin
                  cmd_r <= I_WB.dat[8:0];
                  st_r  <= S_EXEC;
                end
              end
              default: ;
            endcase
          end
        end
        S_EXEC: begin
          st_r <= S_IDLE;
          case (op)
            OPC_SEI: ccr_r[CCR_I] <= 1'b1;
            OPC_STA: begin
              mem_r.addr  <= opnd_r;
              mem_r.wdata <= a_r;
              mem_r.we    <= 1'b1;
              ccr_r       <= sta_ccr;
            end
            OPC_STX: begin
              mem_r.addr  <= opnd_r;
              mem_r.wdata <= x_r;
              mem_r.we    <= 1'b1;
              ccr_r       <= stx_ccr;
            end
            OPC_STORE_INDEX_PAIR: begin
              mem_r.addr  <= opnd_r;
              mem_r.wdata <= h_r;
              mem_r.we    <= 1'b1;
              ccr_r       <= store_index_pair_ccr;
              st_r        <= S_STORE_INDEX_PAIR_LO;
            end
            OPC_SUB: begin
              if (sub_imm) begin
                a_r   <= sub_r;
                ccr_r <= sub_ccr;
              end else begin
                mem_r.addr <= opnd_r;
                mem_r.re   <= 1'b1;
                st_r       <= S_SUB_RD;
              end
            end
            OPC_STOP: begin
              stop_r.irq_pin_en <= 1'b1;
              ccr_r[CCR_I]      <= 1'b0;
              st_r              <= S_STOP_OSC;
            end
            OPC_SWI: begin
              pc_r  <= pc_r + 16'h0001;
              cnt_r <= 3'h0;
              st_r  <= S_PUSH;
            end
            OPC_TAP: begin
              ccr_r     <= a_r | CCR_ONES;
              tap_dly_r <= ccr_r[CCR_I] && !a_r[CCR_I];
            end
            default: ;                          // Unknown opcode: no effect
          endcase
        end
        S_SUB_RD: begin
          a_r   <= sub_r;
          ccr_r <= sub_ccr;
          st_r  <= S_IDLE;
        end
        S_STORE_INDEX_PAIR_LO: begin
          mem_r.addr  <= opnd_r + 16'h0001;
          mem_r.wdata <= x_r;
          mem_r.we    <= 1'b1;
          st_r        <= S_IDLE;
        end
        S_PUSH: begin
          // Stack grows down, one byte per cycle; I is set after the flags
          mem_r.addr  <= sp_r;
          mem_r.wdata <= push_byte;
          mem_r.we    <= 1'b1;
          sp_r        <= sp_r - 16'h0001;
          cnt_r       <= cnt_r + 3'h1;
          if (cnt_r == PUSH_LAST) begin
            ccr_r[CCR_I] <= 1'b1;
            vec_r        <= VEC_SWI;
            st_r         <= S_VEC_HI;
          end
        end
        S_VEC_HI: begin
          mem_r.addr <= vec_r;
          mem_r.re   <= 1'b1;
          st_r       <= S_VEC_LO;
        end
        S_VEC_LO: begin
          pc_r[15:8] <= I_MEM_RDATA;
          mem_r.addr <= vec_r + 16'h0001;
          mem_r.re   <= 1'b1;
          st_r       <= S_VEC_END;
        end
        S_VEC_END: begin
          pc_r[7:0] <= I_MEM_RDATA;
          st_r      <= S_IDLE;
        end
        S_STOP_OSC: begin
          stop_r.level  <= stop_lvl;
          stop_r.osc_en <= dbg_en;
          st_r          <= S_STOPPED;
        end
        S_STOPPED: begin
          if (deep_exit) begin
            // Deep exit looks like power-on: reset state, reset vector
            stop_r   <= '0;
            stop_r.osc_en   <= 1'b1;
            stop_r.self_clk <= 1'b1;
            ccr_r    <= CCR_RESET;
            sp_r     <= SP_RESET;
            a_r      <= 8'h00;
            x_r      <= 8'h00;
            h_r      <= 8'h00;
            vec_r    <= VEC_RST;
            por_r    <= 1'b1;
            st_r     <= S_VEC_HI;
          end else if (light_exit) begin
            stop_r.level    <= LVL_RUN;
            stop_r.osc_en   <= 1'b1;
            stop_r.self_clk <= 1'b1;
            wake_r          <= 1'b1;
            st_r            <= S_IDLE;
          end
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Checks
  sequence s_push5;
    O_MEM.we [*5];
  endsequence

  sequence s_vec_reads;
    (O_MEM.re && O_MEM.addr == VEC_SWI) ##1
    (O_MEM.re && O_MEM.addr == VEC_SWI + 16'h0001);
  endsequence

  chk_sei_one_cycle: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_SEI) |=>
      ccr_r[CCR_I] && st_r == S_IDLE
      && ccr_r[7:4] == $past(ccr_r[7:4]) && ccr_r[2:0] == $past(ccr_r[2:0]))
    else $error("mask set not done in one cycle");

  chk_sei_late_mask: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_SEI && !ccr_r[CCR_I] && !tap_dly_r)
      |-> O_INT_ALLOW ##1 !O_INT_ALLOW)
    else $error("mask changed before end of its cycle");

  chk_mask_blocks: assert property (@(posedge I_CLK)
    disable iff (I_RST)
    ccr_r[CCR_I] |-> !O_INT_ALLOW)
    else $error("interrupts allowed while masked");

  chk_sta_store: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_STA) |=>
      O_MEM.we && O_MEM.wdata == $past(a_r) && !ccr_r[CCR_V]
      && ccr_r[CCR_N] == $past(a_r[7]) && a_r == $past(a_r))
    else $error("accumulator store wrong");

  chk_store_index_pair_order: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_STORE_INDEX_PAIR) |=>
      (O_MEM.we && O_MEM.addr == $past(opnd_r) && O_MEM.wdata == $past(h_r))
      ##1 (O_MEM.we && O_MEM.addr == $past(opnd_r, 2) + 16'h0001))
    else $error("index pair store order wrong");

  chk_sub_carry: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_SUB_RD) |=>
      ccr_r[CCR_C] == ($past(sub_m) > $past(a_r))
      && a_r == $past(a_r) - $past(sub_m))
    else $error("subtract carry wrong");

  chk_sub_ovf: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_SUB_RD && a_r[7] != sub_m[7]) |=>
      ccr_r[CCR_V] == (a_r[7] != $past(a_r[7])))
    else $error("subtract overflow wrong");

  chk_swi_push: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_SWI) |=> ##1
      (O_MEM.wdata == $past(pc_r[7:0], 2) + 8'h01) and s_push5)
    else $error("trap stacking wrong");

  chk_swi_vector: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_PUSH && cnt_r == PUSH_LAST) |=> ccr_r[CCR_I] ##1 s_vec_reads)
    else $error("trap vector fetch wrong");

  chk_tap_delay: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_EXEC && op == OPC_TAP && ccr_r[CCR_I] && !a_r[CCR_I])
      |=> !O_INT_ALLOW ##1 O_INT_ALLOW)
    else $error("transfer hold-off missing");

  chk_dbg_light: assert property (@(posedge I_CLK)
    disable iff (I_RST || !I_CE)
    (st_r == S_STOP_OSC && dbg_en) |=>
      O_STOP.osc_en && O_STOP.level == LVL_LIGHT)
    else $error("debug stop not light");

endmodule

`default_nettype wire

/* csto_mem_model.sv */
// Byte memory standing behind the execution slice's memory port.
// Assumes one clock and zero-wait reads, as the core expects.
`timescale 1ns/1ps
`default_nettype none
module csto_mem_model (
  // Clock and memory port
  input  wire logic                I_CLK,
  input  wire csto_pkg::csto_mem_t I_MEM,
  output logic [7:0]               O_RDATA
);
  import csto_pkg::*;
  logic [7:0] mem [0:65535];
  // Outside a read the bus shows inverted data, never a stale byte
  assign O_RDATA = I_MEM.re ? mem[I_MEM.addr] : ~mem[I_MEM.addr];
  // One byte stored per write strobe; bench may preload bytes too
  always @(posedge I_CLK) begin
    if (I_MEM.we) begin
      mem[I_MEM.addr] <= I_MEM.wdata;
    end
  end
endmodule
`default_nettype wire

/* csto_pkg.sv */
// Shared constants, types and register map of the store/subtract/trap
// execution slice. Assumes a classic Wishbone register bus and a
// zero-wait byte-wide memory port on the same clock.
`default_nettype none

package csto_pkg;

  // Wishbone geometry
  localparam int WB_AW = 8;
  localparam int WB_DW = 32;

  // Register byte offsets
  localparam logic [WB_AW-1:0] REG_CMD    = 8'h00;
  localparam logic [WB_AW-1:0] REG_OPND   = 8'h04;
  localparam logic [WB_AW-1:0] REG_ACC    = 8'h08;
  localparam logic [WB_AW-1:0] REG_SPPC   = 8'h0C;
  localparam logic [WB_AW-1:0] REG_FLAGS  = 8'h10;
  localparam logic [WB_AW-1:0] REG_CFG    = 8'h14;
  localparam logic [WB_AW-1:0] REG_STATUS = 8'h18;

  // Field positions
  localparam int CMD_PRE_BIT = 8;  // Prebyte flag in command word
  localparam int CFG_DBG_BIT = 2;  // Debug enable bit in config
  localparam int ST_BUSY     = 0;
  localparam int ST_STOPPED  = 1;
  localparam int ST_LVL_LO   = 2;
  localparam int ST_ALLOW    = 4;

  // Flag register bit positions
  localparam int CCR_V = 7;
  localparam int CCR_H = 4;
  localparam int CCR_I = 3;
  localparam int CCR_N = 2;
  localparam int CCR_Z = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_ONES  = 8'h60;
  localparam logic [7:0] CCR_RESET = 8'h68;

  // Opcodes and opcode nibbles
  localparam logic [7:0] OP_SEI      = 8'h9B;
  localparam logic [7:0] OP_STOP     = 8'h8E;
  localparam logic [7:0] OP_SWI      = 8'h83;
  localparam logic [7:0] OP_TAP      = 8'h84;
  localparam logic [7:0] OP_STORE_INDEX_PAIR_DIR = 8'h35;
  localparam logic [7:0] OP_STORE_INDEX_PAIR_EXT = 8'h96;
  localparam logic [7:0] OP_STORE_INDEX_PAIR_SP1 = 8'hFF;
  localparam logic [3:0] LO_SUB = 4'h0;
  localparam logic [3:0] LO_STA = 4'h7;
  localparam logic [3:0] LO_STX = 4'hF;
  localparam logic [3:0] HI_IMM = 4'hA;
  localparam logic [3:0] HI_DIR = 4'hB;
  localparam logic [3:0] HI_IX  = 4'hF;
  localparam logic [3:0] HI_SP2 = 4'hD;
  localparam logic [3:0] HI_SP1 = 4'hE;

  // Vectors, reset values, stop levels
  localparam logic [15:0] VEC_SWI  = 16'hFFFC;
  localparam logic [15:0] VEC_RST  = 16'hFFFE;
  localparam logic [15:0] SP_RESET = 16'h00FF;
  localparam logic [1:0]  LVL_RUN   = 2'h0;
  localparam logic [1:0]  LVL_DEEP  = 2'h1;
  localparam logic [1:0]  LVL_MID   = 2'h2;
  localparam logic [1:0]  LVL_LIGHT = 2'h3;
  localparam logic [2:0]  PUSH_LAST = 3'h4;

  typedef enum logic [3:0] {
    OPC_NONE, OPC_SEI, OPC_STA, OPC_STORE_INDEX_PAIR, OPC_STX,
    OPC_SUB, OPC_STOP, OPC_SWI, OPC_TAP
  } csto_op_t;

  typedef enum logic [3:0] {
    S_IDLE, S_EXEC, S_SUB_RD, S_STORE_INDEX_PAIR_LO, S_PUSH, S_VEC_HI,
    S_VEC_LO, S_VEC_END, S_STOP_OSC, S_STOPPED
  } csto_state_t;

  typedef struct packed {
    logic             cyc;
    logic             stb;
    logic             we;
    logic [WB_AW-1:0] adr;
    logic [3:0]       sel;
    logic [WB_DW-1:0] dat;
  } csto_wb_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        re;
  } csto_mem_t;

  typedef struct packed {
    logic       irq_pin_en;
    logic       osc_en;
    logic       self_clk;
    logic [1:0] level;
  } csto_stop_t;

endpackage

`default_nettype wire
